// File: bench/pirq_monitor.sv
// assertion checker on the ports of the peripheral interrupt block
`timescale 1ns/1ps
module pirq_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // events and request
  input wire logic        nvm_write_done,
  input wire logic        conversion_done,
  input wire logic        period_match,
  input wire logic        counter_overflow,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_done;
  logic mapped;
  assign rd_done = psel && penable && pready && !pwrite;
  assign mapped  = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic flag_setup;
  assign flag_setup = psel && !penable && !pwrite && paddr == pirq_pkg::ADDR_FLAGS && ce;
  // read data is a setup-edge snapshot; an idle bus cycle may sit between event and setup,
  // in which no write can clear the flag
  property flag_seen(ev, int b);
    ev && ce ##1 (flag_setup or (!psel ##1 flag_setup)) |=> prdata[b];
  endproperty
  upper_zero_a: assert property (rd_done |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  unused_bit_a: assert property (rd_done && paddr inside {8'h00, 8'h04} |-> !prdata[4])
    else $error("bit 4 read back as one");
  nvm_flag_a: assert property (flag_seen(nvm_write_done, pirq_pkg::BIT_NVM_WRITE_DONE))
    else $error("write done flag not set");
  conv_flag_a: assert property (flag_seen(conversion_done, pirq_pkg::BIT_CONVERSION_DONE))
    else $error("conversion flag not set");
  match_flag_a: assert property (flag_seen(period_match, pirq_pkg::BIT_PERIOD_MATCH))
    else $error("period match flag not set");
  ovf_flag_a: assert property (flag_seen(counter_overflow, 0))
    else $error("overflow flag not set");
  zero_wait_a: assert property (psel && !penable && ce ##1 psel && penable && ce |-> pready)
    else $error("access phase not answered at once");
  unmapped_err_a: assert property (psel && penable && pready |-> pslverr == !mapped)
    else $error("error response does not match address");
  ready_gate_a: assert property (pready |-> ce && psel && penable)
    else $error("ready outside an enabled access");
  cover property ($rose(irq));
  cover property (rd_done && pslverr);
  cover property (rd_done && paddr == pirq_pkg::ADDR_FLAGS && prdata[7:0] != 8'h00);
endmodule
bind pirq_top pirq_monitor u_pirq_monitor (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .nvm_write_done, .conversion_done, .period_match,
  .counter_overflow, .irq);

// File: bench/tb_pirq_top.sv
// self-checking bench for the peripheral interrupt enable/flag block
`timescale 1ns/1ps
module tb_pirq_top;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  ev;
  logic        cmp_match;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          compares;
  int          cyc;

  pirq_top u_pirq_top (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'h1), .prdata, .pready, .pslverr,
    .nvm_write_done(ev[7]), .conversion_done(ev[6]), .capture_event(ev[5]),
    .compare_match(cmp_match), .comparator_out(ev[3]), .osc_fail(ev[2]),
    .period_match(ev[1]), .counter_overflow(ev[0]), .irq
  );

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // --------------------------------------------------------------
  // bus and event drivers
  // --------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the write lands, and read data is taken, at the edge that sees ready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge pclk) ev <= m;
    @(posedge pclk) ev <= 8'h00;
  endtask

  task automatic irqchk(input logic exp);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    rdchk(pirq_pkg::ADDR_ENABLE, 32'h0);
    rdchk(pirq_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b1, pirq_pkg::ADDR_ENABLE, 32'hff);
    rdchk(pirq_pkg::ADDR_ENABLE, {24'h0, pirq_pkg::IMPL_MASK});
    apb(1'b1, pirq_pkg::ADDR_FLAGS, 32'h10);
    rdchk(pirq_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b1, pirq_pkg::ADDR_ENABLE, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic t_events();
    int bits[6] = '{7, 6, 3, 2, 1, 0};
    foreach (bits[i]) begin
      pulse(8'h01 << bits[i]);
      rdchk(pirq_pkg::ADDR_FLAGS, 32'h1 << bits[i]);
      apb(1'b1, pirq_pkg::ADDR_CLEAR, 32'hff);
    end
  endtask

  task automatic t_ccp();
    apb(1'b1, pirq_pkg::ADDR_CONTROL, {28'h0, pirq_pkg::CCP_MODE_CAPTURE, 2'b00});
    pulse(8'h20);
    rdchk(pirq_pkg::ADDR_FLAGS, 32'h20);
    apb(1'b1, pirq_pkg::ADDR_CLEAR, 32'hff);
    apb(1'b1, pirq_pkg::ADDR_CONTROL, {28'h0, pirq_pkg::CCP_MODE_COMPARE, 2'b00});
    @(posedge pclk) cmp_match <= 1'b1;
    @(posedge pclk) cmp_match <= 1'b0;
    rdchk(pirq_pkg::ADDR_FLAGS, 32'h20);
    apb(1'b1, pirq_pkg::ADDR_CLEAR, 32'hff);
    apb(1'b1, pirq_pkg::ADDR_CONTROL, {28'h0, pirq_pkg::CCP_MODE_PWM, 2'b00});
    pulse(8'h20);
    rdchk(pirq_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b1, pirq_pkg::ADDR_CONTROL, 32'h0);
  endtask

  // frozen clock enable: events are not seen and the bus answer waits
  task automatic t_ce();
    @(posedge pclk) ce <= 1'b0;
    pulse(8'h02);
    @(posedge pclk) ce <= 1'b1;
    rdchk(pirq_pkg::ADDR_FLAGS, 32'h0);
    fork
      rdchk(pirq_pkg::ADDR_ENABLE, 32'h0);
      begin
        @(posedge pclk) ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join
  endtask

  task automatic t_irq();
    apb(1'b1, pirq_pkg::ADDR_CONTROL, 32'h3);
    pulse(8'h01);
    irqchk(1'b0);
    apb(1'b1, pirq_pkg::ADDR_CLEAR, 32'hff);
    apb(1'b1, pirq_pkg::ADDR_ENABLE, 32'h01);
    irqchk(1'b0);
    pulse(8'h01);
    irqchk(1'b1);
    apb(1'b1, pirq_pkg::ADDR_CONTROL, 32'h1);
    irqchk(1'b0);
    apb(1'b1, pirq_pkg::ADDR_CONTROL, 32'h2);
    irqchk(1'b0);
    apb(1'b1, pirq_pkg::ADDR_CONTROL, 32'h3);
    irqchk(1'b1);
    rdchk(pirq_pkg::ADDR_PENDING, 32'h01);
    apb(1'b1, pirq_pkg::ADDR_CLEAR, 32'h01);
    irqchk(1'b0);
  endtask

  // event lands on the very edge that takes the clearing write
  task automatic t_race();
    fork
      apb(1'b1, pirq_pkg::ADDR_CLEAR, 32'h01);
      begin
        repeat (2) @(posedge pclk);
        ev <= 8'h01;
        @(posedge pclk);
        ev <= 8'h00;
      end
    join
    rdchk(pirq_pkg::ADDR_FLAGS, 32'h01);
  endtask

  initial begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    ce        = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    ev        = 8'h00;
    cmp_match = 1'b0;
    err_total = 0;
    compares  = 0;
    cyc       = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_events();
    t_ccp();
    t_ce();
    t_irq();
    t_race();
    stop_test();
  end
endmodule

// File: design/pirq_event_detect.sv
// turns peripheral conditions into flag set requests; comparator and oscillator are edge-detected, ccp_mode picks capture or compare, others pass through
`timescale 1ns/1ps
module pirq_event_detect (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // mode of the capture/compare unit
  input  wire logic [1:0] ccp_mode,
  // peripheral conditions
  input  wire logic       nvm_write_done,
  input  wire logic       conversion_done,
  input  wire logic       capture_event,
  input  wire logic       compare_match,
  input  wire logic       comparator_out,
  input  wire logic       osc_fail,
  input  wire logic       period_match,
  input  wire logic       counter_overflow,
  // set requests
  pirq_flag_if.detect     evt
);

  logic cmp_prev;
  logic cmp_armed;
  logic osc_prev;
  logic ccp_hit;

  // ----------------------------------------------------------------
  // history of level inputs
  // ----------------------------------------------------------------
  // comparator history is armed only after the first sample, so a high
  // level at reset release is not mistaken for a change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_prev  <= 1'b0;
      cmp_armed <= 1'b0;
      osc_prev  <= 1'b0;
    end else if (ce) begin
      cmp_prev  <= comparator_out;
      cmp_armed <= 1'b1;
      osc_prev  <= osc_fail;
    end
  end

  // ----------------------------------------------------------------
  // set vector
  // ----------------------------------------------------------------
  always_comb begin
    ccp_hit = 1'b0;
    unique case (ccp_mode)
      pirq_pkg::CCP_MODE_CAPTURE: ccp_hit = capture_event;
      pirq_pkg::CCP_MODE_COMPARE: ccp_hit = compare_match;
      pirq_pkg::CCP_MODE_OFF,
      pirq_pkg::CCP_MODE_PWM:     ccp_hit = 1'b0;
    endcase
  end

  always_comb begin
    evt.set_evt = 8'h00;
    evt.set_evt[pirq_pkg::BIT_NVM_WRITE_DONE]   = nvm_write_done;
    evt.set_evt[pirq_pkg::BIT_CONVERSION_DONE]  = conversion_done;
    evt.set_evt[pirq_pkg::BIT_CAPTURE_COMPARE]  = ccp_hit;
    evt.set_evt[pirq_pkg::BIT_COMPARATOR]       = cmp_armed &
                                                  (comparator_out ^ cmp_prev);
    evt.set_evt[pirq_pkg::BIT_OSC_FAIL]         = osc_fail & ~osc_prev;
    evt.set_evt[pirq_pkg::BIT_PERIOD_MATCH]     = period_match;
    evt.set_evt[pirq_pkg::BIT_COUNTER_OVERFLOW] = counter_overflow;
  end

endmodule

// File: design/pirq_flag_bank.sv
// sticky peripheral interrupt flags with software write and clear
`timescale 1ns/1ps
module pirq_flag_bank (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // flag traffic
  pirq_flag_if.bank fb
);

  logic [7:0] flags;
  logic [7:0] next_flags;

  // ----------------------------------------------------------------
  // next value: software first, hardware set on top
  // ----------------------------------------------------------------
  always_comb begin
    next_flags = flags;
    if (fb.wr_en) begin
      next_flags = fb.wr_data;
    end else if (fb.clr_en) begin
      next_flags = flags & ~fb.clr_data;
    end
    // set applied last so no event is lost to a same-cycle clear
    next_flags = (next_flags | fb.set_evt) & pirq_pkg::IMPL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= pirq_pkg::RESET_FLAGS;
    end else if (ce) begin
      flags <= next_flags;
    end
  end

  assign fb.flags = flags;

endmodule

// File: design/pirq_flag_if.sv
// bundle between register front end, event detector and flag bank
`timescale 1ns/1ps
interface pirq_flag_if;
  logic [7:0] set_evt;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       clr_en;
  logic [7:0] clr_data;
  logic [7:0] flags;

  modport detect (output set_evt);
  modport bank   (input set_evt, input wr_en, input wr_data, input clr_en, input clr_data,
                  output flags);
  modport ctrl   (output wr_en, output wr_data, output clr_en, output clr_data,
                  input flags);
endinterface

// File: design/pirq_pkg.sv
// constants, register map and field layout of the peripheral interrupt enable/flag block
//
// Contract
// - no peripheral interrupt request unless the peripheral group gate bit is set
// - interrupt request only while global allow is set; clearing it blocks everything
// - flags set on their events regardless of enable, gate and global allow bits
// - enable register bits 7..0: nvm, conversion, ccp, none, comparator, osc, t2, t1
// - flag register uses the same bit positions as the enable register, reset 0
// - bit 4 of enable and flag registers reads zero and ignores writes
// - flag bit 7 set when a nonvolatile write finishes, held until cleared
// - flag bit 6 set when an analog conversion completes
// - in capture mode flag bit 5 set on timer-one capture; unused in pwm
// - in compare mode flag bit 5 set on timer-one compare match
// - flag bit 3 set whenever the comparator output changes state
// - flag bit 2 set when the system oscillator fails over to internal oscillator
// - flag bit 1 set when timer-two count equals its period
// - flag bit 0 set when timer-one overflows
package pirq_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE  = 8'h00;
  localparam logic [7:0] ADDR_FLAGS   = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CLEAR   = 8'h0c;
  localparam logic [7:0] ADDR_PENDING = 8'h10;

  // ----------------------------------------------------------------
  // bit positions of enable and flag registers
  // ----------------------------------------------------------------
  localparam int BIT_NVM_WRITE_DONE   = 7;
  localparam int BIT_CONVERSION_DONE  = 6;
  localparam int BIT_CAPTURE_COMPARE  = 5;
  localparam int BIT_UNUSED           = 4;
  localparam int BIT_COMPARATOR       = 3;
  localparam int BIT_OSC_FAIL         = 2;
  localparam int BIT_PERIOD_MATCH     = 1;
  localparam int BIT_COUNTER_OVERFLOW = 0;

  // implemented bits: everything but bit 4
  localparam logic [7:0] IMPL_MASK    = 8'hef;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_IRQ_ALLOW      = 0;
  localparam int BIT_PERIPHERAL_GROUP_GATE = 1;
  localparam int POS_CCP_MODE              = 2;
  localparam logic [7:0] CONTROL_MASK      = 8'h0f;

  // capture/compare unit operating modes
  localparam logic [1:0] CCP_MODE_OFF      = 2'h0;
  localparam logic [1:0] CCP_MODE_CAPTURE  = 2'h1;
  localparam logic [1:0] CCP_MODE_COMPARE  = 2'h2;
  localparam logic [1:0] CCP_MODE_PWM      = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_ENABLE  = 8'h00;
  localparam logic [7:0] RESET_FLAGS   = 8'h00;
  localparam logic [7:0] RESET_CONTROL = 8'h00;

endpackage

// File: design/pirq_top.sv
// peripheral interrupt enable/flag block with apb register access
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module pirq_top (
  // clock, reset, clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // peripheral conditions
  input  wire logic        nvm_write_done,
  input  wire logic        conversion_done,
  input  wire logic        capture_event,
  input  wire logic        compare_match,
  input  wire logic        comparator_out,
  input  wire logic        osc_fail,
  input  wire logic        period_match,
  input  wire logic        counter_overflow,
  // interrupt request
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]  enable;
  logic [7:0]  control;
  logic [7:0]  pending;
  logic        answer_ok;
  logic        unmapped_q;
  logic        access_done;
  logic        wr_fire;
  logic        low_lane;
  logic [31:0] read_mux;
  logic        read_unmapped;
  logic        global_irq_allow;
  logic        peripheral_group_gate;
  logic [1:0]  ccp_mode;

  pirq_flag_if fif ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == pirq_pkg::ADDR_ENABLE)  ||
                (addr == pirq_pkg::ADDR_FLAGS)   ||
                (addr == pirq_pkg::ADDR_CONTROL) ||
                (addr == pirq_pkg::ADDR_CLEAR)   ||
                (addr == pirq_pkg::ADDR_PENDING);
  endfunction

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] reg_addr,
                                  input logic fire);
    wr_hit = fire && (addr == reg_addr);
  endfunction

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // read data is latched in the setup cycle, so every access completes
  // in its first access cycle; a low clock enable simply stretches it
  assign pready      = answer_ok & ce;
  assign pslverr     = answer_ok & ce & unmapped_q;
  assign access_done = psel & penable & pready;
  assign wr_fire     = access_done & pwrite;
  assign low_lane    = pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      answer_ok  <= 1'b0;
      unmapped_q <= 1'b0;
    end else if (ce) begin
      if (access_done) begin
        answer_ok  <= 1'b0;
        unmapped_q <= 1'b0;
      end else if (psel && !answer_ok) begin
        answer_ok  <= 1'b1;
        unmapped_q <= read_unmapped;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    read_mux      = 32'h0000_0000;
    read_unmapped = !is_mapped(paddr);
    unique case (paddr)
      pirq_pkg::ADDR_ENABLE:  read_mux[7:0] = enable & pirq_pkg::IMPL_MASK;
      pirq_pkg::ADDR_FLAGS:   read_mux[7:0] = fif.flags & pirq_pkg::IMPL_MASK;
      pirq_pkg::ADDR_CONTROL: read_mux[7:0] = control;
      pirq_pkg::ADDR_PENDING: read_mux[7:0] = pending;
      default:                read_mux      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !answer_ok) begin
      prdata <= read_mux;
    end
  end

  // ----------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= pirq_pkg::RESET_ENABLE;
    end else if (ce && low_lane && wr_hit(paddr, pirq_pkg::ADDR_ENABLE, wr_fire)) begin
      enable <= pwdata[7:0] & pirq_pkg::IMPL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // control register: global allow, group gate, capture/compare mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= pirq_pkg::RESET_CONTROL;
    end else if (ce && low_lane && wr_hit(paddr, pirq_pkg::ADDR_CONTROL, wr_fire)) begin
      control <= pwdata[7:0] & pirq_pkg::CONTROL_MASK;
    end
  end

  assign global_irq_allow      = control[pirq_pkg::BIT_GLOBAL_IRQ_ALLOW];
  assign peripheral_group_gate = control[pirq_pkg::BIT_PERIPHERAL_GROUP_GATE];
  assign ccp_mode              = control[pirq_pkg::POS_CCP_MODE +: 2];

  // ----------------------------------------------------------------
  // flag traffic toward the bank
  // ----------------------------------------------------------------
  // the flag register stays writable as a whole; the clear register
  // lets software drop single flags without a read-modify-write race
  assign fif.wr_en    = low_lane && wr_hit(paddr, pirq_pkg::ADDR_FLAGS, wr_fire);
  assign fif.wr_data  = pwdata[7:0] & pirq_pkg::IMPL_MASK;
  assign fif.clr_en   = low_lane && wr_hit(paddr, pirq_pkg::ADDR_CLEAR, wr_fire);
  assign fif.clr_data = pwdata[7:0];

  pirq_event_detect u_detect (
    .pclk             (pclk),
    .presetn          (presetn),
    .ce               (ce),
    .ccp_mode         (ccp_mode),
    .nvm_write_done   (nvm_write_done),
    .conversion_done  (conversion_done),
    .capture_event    (capture_event),
    .compare_match    (compare_match),
    .comparator_out   (comparator_out),
    .osc_fail         (osc_fail),
    .period_match     (period_match),
    .counter_overflow (counter_overflow),
    .evt              (fif.detect)
  );

  pirq_flag_bank u_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .fb      (fif.bank)
  );

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // flags keep collecting while enables are off; stale ones fire as soon
  // as the enable is set, which is why software clears them first
  assign pending = enable & fif.flags & pirq_pkg::IMPL_MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= global_irq_allow && peripheral_group_gate && (|pending);
    end
  end

endmodule
